// *** pwr_clk_params.svh ***
`ifndef PWR_CLK_PARAMS_SVH
`define PWR_CLK_PARAMS_SVH

// register byte offsets
`define OFS_CLKCTRL   8'h00
`define OFS_CLKSTAT   8'h04
`define OFS_PWRCTRL   8'h08
`define OFS_PWRSTAT   8'h0c
`define OFS_EVRISE    8'h10
`define OFS_EVFALL    8'h14
`define OFS_EVMASK    8'h18
`define OFS_EVPEND    8'h1c
`define OFS_EVROUTE0  8'h20

// clock control fields
`define CLK_EXTSEL_BIT   0
`define CLK_FAILIE_BIT   1
// clock status fields
`define CST_EXTACT_BIT   0
`define CST_FAIL_BIT     1
`define CST_BOOT_LSB     2
// power control fields
`define PWR_MONEN_BIT    0
`define PWR_MONFALL_BIT  1
`define PWR_MONRISE_BIT  2
`define PWR_SLEEP_BIT    3
`define PWR_STOP_BIT     4
`define PWR_STANDBY_BIT  5
`define PWR_STOPLP_BIT   6
// power status fields
`define PST_MONFLAG_BIT  0
`define PST_MONOUT_BIT   1
`define PST_SBYFLAG_BIT  2

// timing
`define CLKMON_TIMEOUT_NS 1000
`define CLK_PERIOD_NS     4
`define CLKMON_CYCLES     (`CLKMON_TIMEOUT_NS / `CLK_PERIOD_NS)

`define RESET_CLKCTRL 32'h00000000

`endif

// *** pwr_clk_pkg.sv ***
package pwr_clk_pkg;
	typedef enum logic [1:0] {
		BOOT_FLASH,
		BOOT_SYSMEM,
		BOOT_SRAM
	} boot_e;
	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_STOP,
		PM_STANDBY
	} pmode_e;
endpackage

// *** power_clock_mode_control.sv ***
`timescale 1ns/1ps
`include "pwr_clk_params.svh"
// Behaviour
// - any reset restarts the processor on the internal fast oscillator
// - chosen external fast oscillator is watched continuously for lost clock
// - lost external clock falls back to internal oscillator; interrupt only if enabled
// - boot selection pins sampled after reset pick flash, system memory or SRAM
// - power-down reset always active and holds device in reset on low supply
// - enabled supply monitor interrupts on falling, rising or both crossings
// - regulator main in run, main or low power in stop, off in standby
// - regulator enabled out of reset, disabled only in standby
// - sleep stops only the processor clock; any interrupt or event wakes
// - stop gates core clocks, disables PLL and both fast oscillators
// - stop uses normal or low-power regulator as configured
// - any event controller line wakes the device from stop
// - standby powers off core domain, oscillators and PLL
// - standby ends on reset pin, watchdog reset, wakeup pin rise, RTC alarm
// - RTC, watchdog and their clocks keep running in stop and standby
// - nineteen lines, each with own rising, falling trigger and mask
// - each detected request latches into a readable pending flag
// - pulses shorter than a bus clock on external line 0 are still caught
// - up to 51 pins route onto the 16 external lines
module power_clock_mode_control
	import pwr_clk_pkg::*;
#(
	parameter int NLINES  = 19,
	parameter int NEXT    = 16,
	parameter int NPINS   = 51,
	parameter int MONWAIT = `CLKMON_CYCLES
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// supply and pins
	input  wire logic              supplyOk,
	input  wire logic              monBelow,
	input  wire logic [1:0]        bootPins,
	input  wire logic              extOscTick,
	input  wire logic [NPINS-1:0]  gpioPins,
	input  wire logic              extPinPulse,
	input  wire logic              wakeupPin,
	input  wire logic              externalResetPin,
	input  wire logic              watchdogReset,
	input  wire logic              rtcAlarm,
	input  wire logic              usbWakeup,
	input  wire logic              coreIrq,
	// clock, power and reset controls, boot selection and interrupts
	output logic                   coreResetn,
	output logic                   sysClkExt,
	output logic                   cpuClkEn,
	output logic                   periphClkEn,
	output logic                   fastOscEn,
	output logic                   extOscEn,
	output logic                   pllEn,
	output logic                   regMain,
	output logic                   regLowPower,
	output logic                   regEnable,
	output logic                   backupClkEn,
	output logic [1:0]             bootSel,
	output logic                   clkFailIrq,
	output logic                   monIrq,
	output logic [NLINES-1:0]      eventIrq
);

	logic [31:0]        clkCtrl_ff;
	logic               extActive_ff;
	logic               clkFail_ff;
	logic [$clog2(MONWAIT+1)-1:0] monCnt_ff;
	logic [6:0]         pwrCtrl_ff;
	logic               monFlag_ff;
	logic               monPrev_ff;
	logic               sbyFlag_ff;
	logic [NLINES-1:0]  evRise_ff;
	logic [NLINES-1:0]  evFall_ff;
	logic [NLINES-1:0]  evMask_ff;
	logic [NLINES-1:0]  evPend_ff;
	logic [NLINES-1:0]  lineLvl_ff;
	logic [5:0]         route_ff [NEXT];
	logic               pulseTgl_ff;
	logic [2:0]         pulseSync_ff;
	logic               pulseEv;
	logic               wakePrev_ff;
	logic               monTrip;
	logic               extDrop;
	logic               bootTaken_ff;
	pmode_e             mode_ff;
	logic [NLINES-1:0]  lineIn;
	logic [NLINES-1:0]  hit;
	logic [NLINES-1:0]  pendClr;
	logic               wr;
	logic               rd;
	logic               allReset;
	logic               sbyWake;

	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	// supply fault or any reset source forces the whole core into reset
	assign sbyWake  = (mode_ff == PM_STANDBY) && (rtcAlarm || (wakeupPin && !wakePrev_ff));
	assign allReset = !supplyOk || externalResetPin || watchdogReset;

	// line sources: routed pins, supply monitor, rtc alarm, usb wakeup
	genvar g;
	generate
		for (g = 0; g < NEXT; g = g + 1) begin : gRoute
			assign lineIn[g] = (route_ff[g] < 6'(NPINS)) ? gpioPins[route_ff[g]] : 1'b0;
		end
	endgenerate
	// line 0 also takes an asynchronous short pulse catcher, see below
	assign lineIn[NEXT]   = monBelow;
	assign lineIn[NEXT+1] = rtcAlarm;
	assign lineIn[NEXT+2] = usbWakeup;

	always_comb begin
		hit = '0;
		for (int i = 0; i < NLINES; i++) begin
			hit[i] = evMask_ff[i] && ((evRise_ff[i] && lineIn[i] && !lineLvl_ff[i])
				|| (evFall_ff[i] && !lineIn[i] && lineLvl_ff[i])
				|| (i == 0 && evRise_ff[i] && pulseEv));
		end
	end
	assign pendClr = (wr && paddr == `OFS_EVPEND) ? pwdata[NLINES-1:0] : '0;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lineLvl_ff  <= '0;
			evPend_ff   <= '0;
			wakePrev_ff <= 1'b0;
		end else begin
			wakePrev_ff <= wakeupPin;
			lineLvl_ff <= lineIn;
			evPend_ff  <= (evPend_ff & ~pendClr) | hit;
		end
	end

	// short pulse catcher: each rising edge flips a toggle, so no clear has to cross back
	always_ff @(posedge extPinPulse or negedge resetn) begin
		if (!resetn) begin
			pulseTgl_ff <= 1'b0;
		end else begin
			pulseTgl_ff <= !pulseTgl_ff;
		end
	end
	// two flops settle the toggle before anything looks at it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pulseSync_ff <= '0;
		end else begin
			pulseSync_ff <= {pulseSync_ff[1:0], pulseTgl_ff};
		end
	end
	// limitation: two pulses within one bus cycle cancel out
	assign pulseEv = pulseSync_ff[2] ^ pulseSync_ff[1];

	// event configuration registers
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			evRise_ff <= '0;
			evFall_ff <= '0;
			evMask_ff <= '0;
			for (int i = 0; i < NEXT; i++) begin
				route_ff[i] <= 6'(i);
			end
		end else if (wr) begin
			case (paddr)
				`OFS_EVRISE: evRise_ff <= pwdata[NLINES-1:0];
				`OFS_EVFALL: evFall_ff <= pwdata[NLINES-1:0];
				`OFS_EVMASK: evMask_ff <= pwdata[NLINES-1:0];
				default: begin
					for (int i = 0; i < NEXT; i++) begin
						if (paddr == 8'(`OFS_EVROUTE0 + 4*i)) begin
							route_ff[i] <= pwdata[5:0];
						end
					end
				end
			endcase
		end
	end

	// clock selection and failure monitor
	// deselecting, or stop and standby, hands the clock back without raising a failure
	assign extDrop = !clkCtrl_ff[`CLK_EXTSEL_BIT] || mode_ff == PM_STOP || mode_ff == PM_STANDBY;
	assign monTrip = extActive_ff && !extDrop && !extOscTick && monCnt_ff == MONWAIT[$bits(monCnt_ff)-1:0];
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			clkCtrl_ff   <= `RESET_CLKCTRL;
			extActive_ff <= 1'b0;
			clkFail_ff   <= 1'b0;
			monCnt_ff    <= '0;
		end else if (allReset || sbyWake) begin
			clkCtrl_ff   <= `RESET_CLKCTRL;
			extActive_ff <= 1'b0;
			clkFail_ff   <= 1'b0;
			monCnt_ff    <= '0;
		end else begin
			if (wr && paddr == `OFS_CLKCTRL) begin
				clkCtrl_ff <= pwdata;
			end
			if (extActive_ff) begin
				if (extDrop) begin
					extActive_ff <= 1'b0;
					monCnt_ff    <= '0;
				end else if (extOscTick) begin
					monCnt_ff <= '0;
				end else if (monTrip) begin
					extActive_ff <= 1'b0;
					clkFail_ff   <= 1'b1;
					monCnt_ff    <= '0;
				end else begin
					monCnt_ff <= monCnt_ff + 1'b1;
				end
			end else begin
				monCnt_ff    <= '0;
				extActive_ff <= clkCtrl_ff[`CLK_EXTSEL_BIT] && !clkFail_ff && mode_ff == PM_RUN;
			end
			// fail flag: a new failure wins over the clear
			if (wr && paddr == `OFS_CLKSTAT && pwdata[`CST_FAIL_BIT]
				&& !monTrip) begin
				clkFail_ff <= 1'b0;
			end
		end
	end

	// boot selection taken once after reset release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bootTaken_ff <= 1'b0;
			bootSel      <= BOOT_FLASH;
		end else if (allReset || sbyWake) begin
			bootTaken_ff <= 1'b0;
		end else if (!bootTaken_ff) begin
			bootTaken_ff <= 1'b1;
			bootSel      <= (bootPins == 2'b01) ? BOOT_SYSMEM : (bootPins == 2'b11) ? BOOT_SRAM : BOOT_FLASH;
		end
	end

	// supply threshold monitor
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			monPrev_ff <= 1'b0;
			monFlag_ff <= 1'b0;
		end else begin
			monPrev_ff <= monBelow;
			if (pwrCtrl_ff[`PWR_MONEN_BIT] && ((pwrCtrl_ff[`PWR_MONFALL_BIT] && monBelow && !monPrev_ff)
				|| (pwrCtrl_ff[`PWR_MONRISE_BIT] && !monBelow && monPrev_ff))) begin
				monFlag_ff <= 1'b1;
			end else if (wr && paddr == `OFS_PWRSTAT && pwdata[`PST_MONFLAG_BIT]) begin
				monFlag_ff <= 1'b0;
			end
		end
	end

	// power mode sequencing
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_ff    <= PM_RUN;
			pwrCtrl_ff <= '0;
			sbyFlag_ff <= 1'b0;
		end else if (allReset || sbyWake) begin
			mode_ff    <= PM_RUN;
			pwrCtrl_ff <= '0;
			sbyFlag_ff <= sbyWake;
		end else begin
			if (wr && paddr == `OFS_PWRCTRL) begin
				pwrCtrl_ff <= pwdata[6:0];
			end
			if (wr && paddr == `OFS_PWRSTAT && pwdata[`PST_SBYFLAG_BIT]) begin
				sbyFlag_ff <= 1'b0;
			end
			case (mode_ff)
				PM_RUN: begin
					if (pwrCtrl_ff[`PWR_STANDBY_BIT]) begin
						mode_ff <= PM_STANDBY;
					end else if (pwrCtrl_ff[`PWR_STOP_BIT]) begin
						mode_ff <= PM_STOP;
					end else if (pwrCtrl_ff[`PWR_SLEEP_BIT]) begin
						mode_ff <= PM_SLEEP;
					end
				end
				PM_SLEEP: begin
					if (coreIrq || |hit || monIrq) begin
						mode_ff    <= PM_RUN;
						pwrCtrl_ff[`PWR_SLEEP_BIT] <= 1'b0;
					end
				end
				PM_STOP: begin
					if (|hit) begin
						mode_ff    <= PM_RUN;
						pwrCtrl_ff[`PWR_STOP_BIT] <= 1'b0;
					end
				end
				PM_STANDBY: begin
					mode_ff <= PM_STANDBY;
				end
				default: begin
					mode_ff <= PM_RUN;
				end
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			coreResetn  <= 1'b0;
			sysClkExt   <= 1'b0;
			cpuClkEn    <= 1'b0;
			periphClkEn <= 1'b0;
			fastOscEn   <= 1'b1;
			extOscEn    <= 1'b0;
			pllEn       <= 1'b0;
			regMain     <= 1'b1;
			regLowPower <= 1'b0;
			regEnable   <= 1'b1;
			backupClkEn <= 1'b1;
			clkFailIrq  <= 1'b0;
			monIrq      <= 1'b0;
			eventIrq    <= '0;
		end else begin
			coreResetn  <= !allReset && !sbyWake;
			sysClkExt   <= extActive_ff;
			cpuClkEn    <= mode_ff == PM_RUN;
			periphClkEn <= mode_ff == PM_RUN || mode_ff == PM_SLEEP;
			fastOscEn   <= mode_ff == PM_RUN || mode_ff == PM_SLEEP;
			extOscEn    <= clkCtrl_ff[`CLK_EXTSEL_BIT] && (mode_ff == PM_RUN || mode_ff == PM_SLEEP);
			pllEn       <= 1'b0;
			regMain     <= mode_ff == PM_RUN || mode_ff == PM_SLEEP
				|| (mode_ff == PM_STOP && !pwrCtrl_ff[`PWR_STOPLP_BIT]);
			regLowPower <= mode_ff == PM_STOP && pwrCtrl_ff[`PWR_STOPLP_BIT];
			regEnable   <= mode_ff != PM_STANDBY;
			backupClkEn <= 1'b1;
			clkFailIrq  <= clkFail_ff && clkCtrl_ff[`CLK_FAILIE_BIT];
			monIrq      <= monFlag_ff;
			eventIrq    <= evPend_ff;
		end
	end

	// apb slave: zero wait states, unmapped reads return zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`OFS_CLKCTRL: prdata <= clkCtrl_ff;
					`OFS_CLKSTAT: prdata <= {28'h0, bootSel, clkFail_ff, extActive_ff};
					`OFS_PWRCTRL: prdata <= {25'h0, pwrCtrl_ff};
					`OFS_PWRSTAT: prdata <= {29'h0, sbyFlag_ff, monBelow, monFlag_ff};
					`OFS_EVRISE:  prdata <= 32'(evRise_ff);
					`OFS_EVFALL:  prdata <= 32'(evFall_ff);
					`OFS_EVMASK:  prdata <= 32'(evMask_ff);
					`OFS_EVPEND:  prdata <= 32'(evPend_ff);
					default:      prdata <= '0;
				endcase
			end
		end
	end

	a_regen_standby: assert property (@(posedge mclk) disable iff (!resetn)
		(mode_ff == PM_STANDBY) |=> !regEnable) else $error("regulator on in standby");
	a_stop_lp: assert property (@(posedge mclk) disable iff (!resetn)
		(mode_ff == PM_STOP && pwrCtrl_ff[`PWR_STOPLP_BIT]) |=> regLowPower && !regMain)
		else $error("stop regulator mode wrong");
	a_sleep_clk: assert property (@(posedge mclk) disable iff (!resetn)
		(mode_ff == PM_SLEEP) |=> !cpuClkEn && periphClkEn) else $error("sleep clock gating wrong");
	a_fail_irq: assert property (@(posedge mclk) disable iff (!resetn)
		clkFailIrq |-> $past(clkCtrl_ff[`CLK_FAILIE_BIT])) else $error("fail irq while disabled");
	a_pend_hold: assert property (@(posedge mclk) disable iff (!resetn)
		(|hit) |=> (evPend_ff & $past(hit)) == $past(hit)) else $error("pending not latched");
	a_reset_int: assert property (@(posedge mclk) disable iff (!resetn)
		allReset |=> !extActive_ff ##1 !sysClkExt) else $error("reset left external clock");
	a_stop_osc: assert property (@(posedge mclk) disable iff (!resetn)
		(mode_ff == PM_STOP) |=> !fastOscEn && !pllEn) else $error("oscillators on in stop");
	a_supply_rst: assert property (@(posedge mclk) disable iff (!resetn)
		!supplyOk |=> !coreResetn) else $error("no reset on low supply");

endmodule

// *** far_side_model.sv ***
`timescale 1ns/1ps
module far_side_model (
	// clock
	input  wire logic mclk,
	// external oscillator
	input  wire logic extOscEn,
	input  wire logic oscAlive,
	output logic      extOscTick
);
	// a dead or disabled crystal gives no edges at all, so the monitor sees a flat line
	initial extOscTick = 1'b0;
	always @(posedge mclk) begin
		extOscTick <= (extOscEn && oscAlive) ? ~extOscTick : 1'b0;
	end
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "pwr_clk_params.svh"
module testbench;
	import pwr_clk_pkg::*;
	localparam int MONWAIT = 8;
	logic        mclk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        supplyOk, monBelow, extOscTick, extPinPulse, wakeupPin, externalResetPin;
	logic        watchdogReset, rtcAlarm, usbWakeup, coreIrq, oscAlive;
	logic [1:0]  bootPins, bootSel;
	logic [50:0] gpioPins;
	logic        coreResetn, sysClkExt, cpuClkEn, periphClkEn, fastOscEn, extOscEn, pllEn;
	logic        regMain, regLowPower, regEnable, backupClkEn, clkFailIrq, monIrq;
	logic [18:0] eventIrq;
	int          n_errors, checks_done;

	power_clock_mode_control #(.MONWAIT(MONWAIT)) uut (
		.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .supplyOk(supplyOk),
		.monBelow(monBelow), .bootPins(bootPins), .extOscTick(extOscTick), .gpioPins(gpioPins),
		.extPinPulse(extPinPulse), .wakeupPin(wakeupPin), .externalResetPin(externalResetPin),
		.watchdogReset(watchdogReset), .rtcAlarm(rtcAlarm), .usbWakeup(usbWakeup), .coreIrq(coreIrq),
		.coreResetn(coreResetn), .sysClkExt(sysClkExt), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
		.fastOscEn(fastOscEn), .extOscEn(extOscEn), .pllEn(pllEn), .regMain(regMain),
		.regLowPower(regLowPower), .regEnable(regEnable), .backupClkEn(backupClkEn), .bootSel(bootSel),
		.clkFailIrq(clkFailIrq), .monIrq(monIrq), .eventIrq(eventIrq)
	);
	far_side_model osc (.mclk(mclk), .extOscEn(extOscEn), .oscAlive(oscAlive), .extOscTick(extOscTick));

	// only the core clock runs here; the bus prescalers sit outside this block
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic final_report;
		if (n_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// waits as long as the slave needs; only the watchdog ends a hung transfer
	task automatic apbXfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apbXfer(1'b1, a, d, q);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apbXfer(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	initial begin
		#50000;
		n_errors++;
		final_report();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{monBelow, extPinPulse, wakeupPin, externalResetPin, watchdogReset, rtcAlarm, usbWakeup} = '0;
		{coreIrq, gpioPins} = '0;
		resetn = 1'b0;
		supplyOk = 1'b1;
		oscAlive = 1'b1;
		bootPins = 2'b01;
		cyc(16);
		resetn <= 1'b1;
		cyc(4);
		check({coreResetn, sysClkExt, cpuClkEn, periphClkEn, fastOscEn}, 5'b10111);
		check({regEnable, regMain, regLowPower, pllEn, backupClkEn}, 5'b11001);
		check(32'(bootSel), 32'h1);
		rdChk(`OFS_CLKSTAT, 32'h4);
		rdChk(8'h40, 32'h0);
		for (int ie = 1; ie >= 0; ie--) begin
			oscAlive <= 1'b1;
			wr(`OFS_CLKCTRL, 32'h1 | 32'(ie << 1));
			cyc(2 * MONWAIT);
			check({sysClkExt, extOscEn}, 2'b11);
			oscAlive <= 1'b0;
			cyc(4 * MONWAIT);
			check({sysClkExt, clkFailIrq}, {1'b0, ie[0]});
			rdChk(`OFS_CLKSTAT, 32'h6);
			wr(`OFS_CLKSTAT, 32'h2);
			wr(`OFS_CLKCTRL, 32'h0);
			check(clkFailIrq, 1'b0);
		end
		for (int k = 0; k < 2; k++) begin
			wr(`OFS_PWRCTRL, (k == 1) ? 32'h5 : 32'h3);
			cyc(2);
			check(monIrq, 1'b0);
			monBelow <= ~monBelow;
			cyc(4);
			check(monIrq, 1'b1);
			rdChk(`OFS_PWRSTAT, (k == 1) ? 32'h1 : 32'h3);
			wr(`OFS_PWRSTAT, 32'h1);
			wr(`OFS_PWRCTRL, 32'h0);
			check(monIrq, 1'b0);
		end
		// line 1 is moved off its default pin to show the routing is real
		wr(`OFS_EVROUTE0 + 8'h04, 32'd40);
		wr(`OFS_EVRISE, 32'h20003);
		wr(`OFS_EVFALL, 32'h2);
		wr(`OFS_EVMASK, 32'h20003);
		gpioPins[40] <= 1'b1;
		cyc(3);
		rdChk(`OFS_EVPEND, 32'h2);
		check(32'(eventIrq), 32'h2);
		wr(`OFS_EVPEND, 32'h2);
		gpioPins[40] <= 1'b0;
		cyc(3);
		rdChk(`OFS_EVPEND, 32'h2);
		wr(`OFS_EVPEND, 32'h2);
		wr(`OFS_EVMASK, 32'h20001);
		gpioPins[40] <= 1'b1;
		cyc(3);
		rdChk(`OFS_EVPEND, 32'h0);
		@(posedge mclk);
		#1 extPinPulse = 1'b1;
		#1 extPinPulse = 1'b0;
		cyc(4);
		rdChk(`OFS_EVPEND, 32'h1);
		wr(`OFS_EVPEND, 32'h1);
		wr(`OFS_PWRCTRL, 32'h8);
		cyc(3);
		check({cpuClkEn, periphClkEn}, 2'b01);
		coreIrq <= 1'b1;
		cyc(3);
		check(cpuClkEn, 1'b1);
		coreIrq <= 1'b0;
		wr(`OFS_PWRCTRL, 32'h0);
		for (int lp = 0; lp < 2; lp++) begin
			wr(`OFS_PWRCTRL, (lp == 1) ? 32'h50 : 32'h10);
			cyc(3);
			check({cpuClkEn, periphClkEn, fastOscEn, extOscEn, pllEn}, 5'b00000);
			check({regMain, regLowPower, regEnable}, {~lp[0], lp[0], 1'b1});
			rtcAlarm <= 1'b1;
			cyc(4);
			check({cpuClkEn, fastOscEn, regMain}, 3'b111);
			rtcAlarm <= 1'b0;
			wr(`OFS_EVPEND, 32'h20000);
			wr(`OFS_PWRCTRL, 32'h0);
		end
		for (int s = 0; s < 3; s++) begin
			wr(`OFS_CLKCTRL, 32'h2);
			wr(`OFS_PWRCTRL, 32'h20);
			cyc(3);
			check({regEnable, fastOscEn, extOscEn, backupClkEn, cpuClkEn}, 5'b00010);
			case (s)
				0: rtcAlarm <= 1'b1;
				1: wakeupPin <= 1'b1;
				default: watchdogReset <= 1'b1;
			endcase
			cyc(3);
			{rtcAlarm, wakeupPin, watchdogReset} <= 3'b000;
			cyc(12);
			check({coreResetn, regEnable, fastOscEn, sysClkExt}, 4'b1110);
			rdChk(`OFS_CLKCTRL, 32'h0);
			if (s < 2)
				rdChk(`OFS_PWRSTAT, 32'h4);
			wr(`OFS_PWRSTAT, 32'h4);
		end
		supplyOk <= 1'b0;
		cyc(3);
		check(coreResetn, 1'b0);
		supplyOk <= 1'b1;
		cyc(6);
		check(coreResetn, 1'b1);
		bootPins <= 2'b11;
		externalResetPin <= 1'b1;
		cyc(3);
		check(coreResetn, 1'b0);
		externalResetPin <= 1'b0;
		cyc(6);
		check({coreResetn, bootSel}, 3'b110);
		final_report();
	end
endmodule
